// file: verilog/ccr_regs.svh
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
// Register indices; the byte address is four times the index.
`define CCR_IDX_CFG        5'h09
`define CCR_IDX_OCAL_HI    5'h0A
`define CCR_IDX_OCAL_LO    5'h0B
`define CCR_IDX_GCAL_HI    5'h0C
`define CCR_IDX_GCAL_LO    5'h0D
`define CCR_IDX_GLOBAL     5'h10
`define CCR_RST_CFG        16'h0000
`define CCR_RST_OCAL_HI    16'h0000
`define CCR_RST_OCAL_LO    16'h0000
`define CCR_RST_GCAL_HI    16'h8000
`define CCR_RST_GCAL_LO    16'h0000
`define CCR_RST_GLOBAL     4'h0
`define CCR_CFG_PHASE_HI   15
`define CCR_CFG_PHASE_LO   6
`define CCR_CFG_BYPASS     2
`define CCR_CFG_SEL_HI     1
`define CCR_CFG_SEL_LO     0
`define CCR_CFG_WMASK      16'hFFC7
`define CCR_LOW_WMASK      16'hFF00
`define CCR_HPF_OFF        4'h0
`define CCR_ADR_IDX_HI     6
`define CCR_ADR_IDX_LO     2
`define CCR_GLOB_WMASK     16'h000F
`define CCR_COEF_HI        3
`endif

// file: verilog/ccr_pkg.sv
package ccr_pkg;
	typedef enum logic [1:0] {
		CCR_IN_PINS,
		CCR_IN_SHORT,
		CCR_IN_TEST_POS,
		CCR_IN_TEST_NEG
	} ccr_input_e;
endpackage : ccr_pkg

// file: verilog/ccr_word16.sv
`include "ccr_regs.svh"
// One 16-bit register with per-bit write mask and byte lane enables.
module ccr_word16 import ccr_pkg::*; #(
	parameter logic [15:0] RESET_VAL = 16'h0000,
	parameter logic [15:0] WMASK     = 16'hFFFF
) (
	input  wire logic        core_clk, // Clock.
	input  wire logic        rst_n,    // Async reset, active low.
	input  wire logic        wr_en,    // Write strobe.
	input  wire logic [1:0]  wr_sel,   // Byte lane enables.
	input  wire logic [15:0] wr_data,  // Write data.
	output logic      [15:0] value     // Stored value.
);
	logic [15:0] value_q;
	wire  [15:0] lane_mask = {{8{wr_sel[1]}}, {8{wr_sel[0]}}} & WMASK;
	wire  [15:0] value_d   = wr_en ? ((value_q & ~lane_mask) | (wr_data & lane_mask)) : value_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end

	assign value = value_q;
endmodule : ccr_word16

// file: verilog/ccr_hpf_select.sv
`include "ccr_regs.svh"
// Resolves the effective high-pass coefficient for channel 0.
module ccr_hpf_select import ccr_pkg::*; (
	input  wire logic       bypass,     // Per-channel bypass bit.
	input  wire logic [3:0] global_coef, // Global coefficient code.
	output logic            hpf_enable, // Filter active.
	output logic      [4:0] hpf_shift   // Coefficient as 2^-shift.
);
	// Code 1 gives 1/4 and each step halves, so the shift is code plus one.
	wire       on_w    = !bypass && (global_coef != `CCR_HPF_OFF);
	wire [4:0] shift_w = {1'b0, global_coef} + 5'h01;

	assign hpf_enable = on_w;
	assign hpf_shift  = on_w ? shift_w : 5'h00;
endmodule : ccr_hpf_select

// file: verilog/ccr_channel0_regs.sv
// Notes on behaviour
// - Config word at index 9h, cleared to zero on reset.
// - Config bits 15:6 are a signed 10-bit phase delay in modulator clocks.
// - Config bit 2 set removes channel 0 high-pass filter regardless of global code.
// - Bypass bit clear (reset) lets the global coefficient code govern filtering.
// - Config bits 1:0 select input; 00 (reset) uses the channel's own pins.
// - Selector 01 shorts the converter inputs together.
// - Selector 10 feeds positive DC test signal, 11 negative.
// - Index Ah holds offset bits 23:8, read/write, reset zero.
// - Index Bh upper byte holds offset bits 7:0, lower byte reads zero.
// - Index Ch holds gain bits 23:8, reset 8000h for unity gain.
// - Index Dh upper byte holds gain bits 7:0, lower byte reads zero.
// - Global code 0000 disables filter; 0001..1111 give 1/4 down to 1/65536.
`include "ccr_regs.svh"
module ccr_channel0_regs import ccr_pkg::*; (
	input  wire logic        core_clk,                     // 20 MHz clock.
	input  wire logic        rst_n,                        // Async reset, active low.
	input  wire logic        wb_cyc_i,                     // Wishbone cycle.
	input  wire logic        wb_stb_i,                     // Wishbone strobe.
	input  wire logic        wb_we_i,                      // Wishbone write enable.
	input  wire logic [31:0] wb_adr_i,                     // Wishbone byte address.
	input  wire logic [3:0]  wb_sel_i,                     // Wishbone byte selects.
	input  wire logic [31:0] wb_dat_i,                     // Wishbone write data.
	output logic      [31:0] wb_dat_o,                     // Wishbone read data.
	output logic             wb_ack_o,                     // Wishbone acknowledge.
	output logic             wb_err_o,                     // Unmapped address answer.
	output logic signed [9:0] channel0_phase_delay,        // Phase delay, modulator clocks.
	output logic             channel0_highpass_bypass,     // Bypass bit as stored.
	output ccr_input_e       channel0_input_select,        // Input selector.
	output logic             channel0_use_pins,            // Positive/negative pins connected.
	output logic             channel0_inputs_shorted,      // Converter inputs shorted.
	output logic             channel0_test_positive,       // Positive DC test applied.
	output logic             channel0_test_negative,       // Negative DC test applied.
	output logic      [3:0]  global_highpass_coefficient,  // Global coefficient code.
	output logic             channel0_highpass_enable,     // Filter active on channel 0.
	output logic      [4:0]  channel0_highpass_shift,      // Coefficient as 2^-shift.
	output logic      [23:0] channel0_offset_cal,          // Combined offset value.
	output logic      [23:0] channel0_gain_cal             // Combined gain value.
);
	logic        ack_q;
	logic [31:0] rdata_q;
	logic        err_q;
	logic [15:0] cfg_w;
	logic [15:0] ocal_hi_w;
	logic [15:0] ocal_lo_w;
	logic [15:0] gcal_hi_w;
	logic [15:0] gcal_lo_w;
	logic [15:0] glob_w;
	logic        hpf_en_w;
	logic [4:0]  hpf_shift_w;

	// Single-cycle answer; ack drops the cycle after it was given.
	wire        req_w    = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	wire [4:0]  idx_w    = wb_adr_i[`CCR_ADR_IDX_HI:`CCR_ADR_IDX_LO];
	wire        hit_up_w = (wb_adr_i[31:`CCR_ADR_IDX_HI+1] == '0) &&
	                       (wb_adr_i[`CCR_ADR_IDX_LO-1:0] == '0);
	wire        sel_cfg  = hit_up_w && (idx_w == `CCR_IDX_CFG);
	wire        sel_oh   = hit_up_w && (idx_w == `CCR_IDX_OCAL_HI);
	wire        sel_ol   = hit_up_w && (idx_w == `CCR_IDX_OCAL_LO);
	wire        sel_gh   = hit_up_w && (idx_w == `CCR_IDX_GCAL_HI);
	wire        sel_gl   = hit_up_w && (idx_w == `CCR_IDX_GCAL_LO);
	wire        sel_gb   = hit_up_w && (idx_w == `CCR_IDX_GLOBAL);
	wire        mapped_w = sel_cfg | sel_oh | sel_ol | sel_gh | sel_gl | sel_gb;
	wire        wr_w     = req_w && wb_we_i && mapped_w;
	wire [1:0]  lanes_w  = wb_sel_i[1:0];

	// Reserved bits 5:3 of the config word are masked so they always read zero.
	ccr_word16 #(.RESET_VAL(`CCR_RST_CFG), .WMASK(`CCR_CFG_WMASK)) u_cfg (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_w && sel_cfg),
		.wr_sel   (lanes_w),
		.wr_data  (wb_dat_i[15:0]),
		.value    (cfg_w)
	);
	ccr_word16 #(.RESET_VAL(`CCR_RST_OCAL_HI)) u_ocal_hi (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_w && sel_oh),
		.wr_sel   (lanes_w),
		.wr_data  (wb_dat_i[15:0]),
		.value    (ocal_hi_w)
	);
	ccr_word16 #(.RESET_VAL(`CCR_RST_OCAL_LO), .WMASK(`CCR_LOW_WMASK)) u_ocal_lo (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_w && sel_ol),
		.wr_sel   (lanes_w),
		.wr_data  (wb_dat_i[15:0]),
		.value    (ocal_lo_w)
	);
	ccr_word16 #(.RESET_VAL(`CCR_RST_GCAL_HI)) u_gcal_hi (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_w && sel_gh),
		.wr_sel   (lanes_w),
		.wr_data  (wb_dat_i[15:0]),
		.value    (gcal_hi_w)
	);
	ccr_word16 #(.RESET_VAL(`CCR_RST_GCAL_LO), .WMASK(`CCR_LOW_WMASK)) u_gcal_lo (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_w && sel_gl),
		.wr_sel   (lanes_w),
		.wr_data  (wb_dat_i[15:0]),
		.value    (gcal_lo_w)
	);
	// The global coefficient lives here because this bank is its only consumer.
	ccr_word16 #(.RESET_VAL({12'h000, `CCR_RST_GLOBAL}), .WMASK(`CCR_GLOB_WMASK)) u_glob (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_w && sel_gb),
		.wr_sel   (lanes_w),
		.wr_data  (wb_dat_i[15:0]),
		.value    (glob_w)
	);

	ccr_hpf_select u_hpf (
		.bypass      (cfg_w[`CCR_CFG_BYPASS]),
		.global_coef (glob_w[`CCR_COEF_HI:0]),
		.hpf_enable  (hpf_en_w),
		.hpf_shift   (hpf_shift_w)
	);

	wire [15:0] rd_mux_w = sel_cfg ? cfg_w :
	                       sel_oh  ? ocal_hi_w :
	                       sel_ol  ? ocal_lo_w :
	                       sel_gh  ? gcal_hi_w :
	                       sel_gl  ? gcal_lo_w :
	                       sel_gb  ? glob_w : 16'h0000;
	wire [31:0] rdata_d  = (req_w && !wb_we_i && mapped_w) ? {16'h0000, rd_mux_w} : rdata_q;
	wire        ack_d    = req_w && mapped_w;
	wire        err_d    = req_w && !mapped_w;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= ack_d;
			err_q   <= err_d;
			rdata_q <= rdata_d;
		end
	end

	wire [1:0] sel_w = cfg_w[`CCR_CFG_SEL_HI:`CCR_CFG_SEL_LO];

	assign wb_ack_o                    = ack_q;
	assign wb_err_o                    = err_q;
	assign wb_dat_o                    = rdata_q;
	assign channel0_phase_delay        = cfg_w[`CCR_CFG_PHASE_HI:`CCR_CFG_PHASE_LO];
	assign channel0_highpass_bypass    = cfg_w[`CCR_CFG_BYPASS];
	assign channel0_input_select       = ccr_input_e'(sel_w);
	assign channel0_use_pins           = (sel_w == CCR_IN_PINS);
	assign channel0_inputs_shorted     = (sel_w == CCR_IN_SHORT);
	assign channel0_test_positive      = (sel_w == CCR_IN_TEST_POS);
	assign channel0_test_negative      = (sel_w == CCR_IN_TEST_NEG);
	assign global_highpass_coefficient = glob_w[`CCR_COEF_HI:0];
	assign channel0_highpass_enable    = hpf_en_w;
	assign channel0_highpass_shift     = hpf_shift_w;
	assign channel0_offset_cal         = {ocal_hi_w, ocal_lo_w[15:8]};
	assign channel0_gain_cal           = {gcal_hi_w, gcal_lo_w[15:8]};
endmodule : ccr_channel0_regs

// file: dv/ccr_channel0_regs_assertions.sv
module ccr_chk import ccr_pkg::*; (
	input wire logic              core_clk,                    // Clock.
	input wire logic              rst_n,                       // Reset, active low.
	input wire logic              wb_cyc_i,                    // Bus cycle.
	input wire logic              wb_stb_i,                    // Bus strobe.
	input wire logic              wb_we_i,                     // Bus write enable.
	input wire logic              wb_ack_o,                    // Bus acknowledge.
	input wire logic              wb_err_o,                    // Bus error.
	input wire logic [31:0]       wb_adr_i,                    // Bus address.
	input wire logic [31:0]       wb_dat_i,                    // Write data.
	input wire logic [31:0]       wb_dat_o,                    // Read data.
	input wire logic [3:0]        wb_sel_i,                    // Byte lanes.
	input wire logic [3:0]        global_highpass_coefficient, // Global code.
	input wire logic signed [9:0] channel0_phase_delay,        // Phase delay.
	input wire ccr_input_e        channel0_input_select,       // Input selector.
	input wire logic              channel0_highpass_bypass,    // Bypass bit.
	input wire logic              channel0_use_pins,           // Pins decode.
	input wire logic              channel0_inputs_shorted,     // Short decode.
	input wire logic              channel0_test_positive,      // Positive test decode.
	input wire logic              channel0_test_negative,      // Negative test decode.
	input wire logic              channel0_highpass_enable,    // Filter active.
	input wire logic [23:0]       channel0_offset_cal          // Combined offset.
);
	timeunit 1ns;
	timeprecision 1ns;
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire full = take && wb_we_i && wb_sel_i[1:0] == 2'h3;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_answer_next: assert property (take |=> wb_ack_o != wb_err_o)
		else $error("no single answer after request");
	a_idle_quiet: assert property (!take |=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");
	a_phase_write: assert property (full && wb_adr_i == 32'h24 |=>
		channel0_phase_delay == $past(wb_dat_i[15:6])) else $error("phase not written");
	a_offset_join: assert property (full && wb_adr_i == 32'h28 |=>
		channel0_offset_cal[23:8] == $past(wb_dat_i[15:0])) else $error("offset high wrong");
	a_low_zero: assert property (wb_ack_o &&
		$past(!wb_we_i && wb_adr_i[5:0] inside {6'h2C, 6'h34})
		|-> wb_dat_o[7:0] == 8'h00) else $error("low byte not zero");
	a_decode_pins: assert property (channel0_use_pins == (channel0_input_select == CCR_IN_PINS))
		else $error("pins decode wrong");
	a_decode_short: assert property (channel0_inputs_shorted == (channel0_input_select == CCR_IN_SHORT))
		else $error("short decode wrong");
	a_decode_test: assert property ({channel0_test_positive, channel0_test_negative} ==
		{channel0_input_select == CCR_IN_TEST_POS, channel0_input_select == CCR_IN_TEST_NEG}) else $error("test decode");
	a_bypass_wins: assert property (channel0_highpass_bypass |-> !channel0_highpass_enable)
		else $error("filter on while bypassed");
	a_global_rules: assert property (!channel0_highpass_bypass |-> channel0_highpass_enable ==
		(global_highpass_coefficient != 4'h0)) else $error("filter not per global code");
	c_write: cover property (full);
	c_error: cover property (wb_err_o);
	c_test_neg: cover property (channel0_test_negative);
endmodule : ccr_chk
bind ccr_channel0_regs ccr_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
	.global_highpass_coefficient(global_highpass_coefficient),
	.channel0_phase_delay(channel0_phase_delay), .channel0_input_select(channel0_input_select),
	.channel0_highpass_bypass(channel0_highpass_bypass), .channel0_use_pins(channel0_use_pins),
	.channel0_inputs_shorted(channel0_inputs_shorted), .channel0_test_positive(channel0_test_positive),
	.channel0_test_negative(channel0_test_negative), .channel0_offset_cal(channel0_offset_cal),
	.channel0_highpass_enable(channel0_highpass_enable));

// file: dv/ccr_channel0_regs_test.sv
module ccr_channel0_regs_test import ccr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [3:0]  wb_sel_i = 4'h0, global_highpass_coefficient;
	logic        wb_ack_o, wb_err_o, er, channel0_highpass_bypass, channel0_use_pins;
	logic        channel0_inputs_shorted, channel0_test_positive, channel0_test_negative;
	logic        channel0_highpass_enable;
	logic signed [9:0] channel0_phase_delay;
	ccr_input_e  channel0_input_select;
	logic [4:0]  channel0_highpass_shift;
	logic [23:0] channel0_offset_cal, channel0_gain_cal;
	logic [15:0] mdl [6];
	logic [31:0] adr_t [6] = '{32'h24, 32'h28, 32'h2C, 32'h30, 32'h34, 32'h40};
	logic [15:0] wm_t [6] = '{16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'h000F};
	logic [15:0] rst_t [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
	int          n_mismatch = 0, compares = 0;
	ccr_channel0_regs dut (
		.core_clk                    (core_clk),
		.rst_n                       (rst_n),
		.wb_cyc_i                    (wb_cyc_i),
		.wb_stb_i                    (wb_stb_i),
		.wb_we_i                     (wb_we_i),
		.wb_adr_i                    (wb_adr_i),
		.wb_sel_i                    (wb_sel_i),
		.wb_dat_i                    (wb_dat_i),
		.wb_dat_o                    (wb_dat_o),
		.wb_ack_o                    (wb_ack_o),
		.wb_err_o                    (wb_err_o),
		.channel0_phase_delay        (channel0_phase_delay),
		.channel0_highpass_bypass    (channel0_highpass_bypass),
		.channel0_input_select       (channel0_input_select),
		.channel0_use_pins           (channel0_use_pins),
		.channel0_inputs_shorted     (channel0_inputs_shorted),
		.channel0_test_positive      (channel0_test_positive),
		.channel0_test_negative      (channel0_test_negative),
		.global_highpass_coefficient (global_highpass_coefficient),
		.channel0_highpass_enable    (channel0_highpass_enable),
		.channel0_highpass_shift     (channel0_highpass_shift),
		.channel0_offset_cal         (channel0_offset_cal),
		.channel0_gain_cal           (channel0_gain_cal)
	);
	always #25 core_clk = ~core_clk;
	// Write masks keep reserved and read-only bits out of the model.
	function automatic logic [15:0] nxt(int i, logic [15:0] d, logic [3:0] s);
		logic [15:0] m = wm_t[i] & {{8{s[1]}}, {8{s[0]}}};
		return (mdl[i] & ~m) | (d & m);
	endfunction : nxt
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(logic [31:0] a, logic w, logic [15:0] d, logic [3:0] s);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {16'h0, d};
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		rd = wb_dat_o;
		er = wb_err_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge core_clk);
	endtask : wb
	task automatic outs();
		logic [3:0] dec;
		logic       filt;
		logic [4:0] shft;
		dec  = {channel0_use_pins, channel0_inputs_shorted, channel0_test_positive,
			channel0_test_negative};
		filt = !mdl[0][2] && mdl[5][3:0] != 4'h0;
		// Code 1 is a quarter and each further code halves it, so the shift sits one above the code.
		shft = filt ? 5'(mdl[5][3:0]) + 5'h01 : 5'h00;
		chk("phase", {22'h0, mdl[0][15:6]}, {22'h0, channel0_phase_delay});
		chk("input select", {30'h0, mdl[0][1:0]}, {30'h0, channel0_input_select});
		chk("input decode", {28'h0, 4'b1000 >> mdl[0][1:0]}, {28'h0, dec});
		chk("bypass", {31'h0, mdl[0][2]}, {31'h0, channel0_highpass_bypass});
		chk("filter on", {31'h0, filt}, {31'h0, channel0_highpass_enable});
		chk("coefficient", {28'h0, mdl[5][3:0]}, {28'h0, global_highpass_coefficient});
		chk("shift", {27'h0, shft}, {27'h0, channel0_highpass_shift});
		chk("offset", {mdl[1], mdl[2][15:8]}, channel0_offset_cal);
		chk("gain", {mdl[3], mdl[4][15:8]}, channel0_gain_cal);
	endtask : outs
	task automatic wr(int i, logic [15:0] d, logic [3:0] s);
		wb(adr_t[i], 1'b1, d, s);
		chk("write answer", 32'h0, {31'h0, er});
		mdl[i] = nxt(i, d, s);
		outs();
	endtask : wr
	task automatic rdc(int i);
		wb(adr_t[i], 1'b0, 16'h0, 4'hF);
		chk("read", {16'h0, mdl[i]}, rd);
	endtask : rdc
	task automatic give_verdict();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h90f4516f));
		for (int r = 0; r < 2; r++) begin
			foreach (mdl[i]) mdl[i] = rst_t[i];
			repeat (6) @(posedge core_clk);
			rst_n <= 1'b1;
			@(posedge core_clk);
			outs();
			for (int i = 0; i < 6; i++) rdc(i);
			for (int k = 0; k < 8; k++) begin
				wr(0, {k[0] ? 10'h200 : 10'h1FF, 3'h7, k[2:0]}, 4'h3);
				wr(5, 16'(k * 5), 4'h1);
			end
			wb(32'h38, 1'b1, 16'hFFFF, 4'hF);
			chk("unmapped", 32'h1, {31'h0, er});
			repeat (80) wr($urandom_range(5), 16'($urandom), 4'($urandom));
			if (r == 0) rst_n <= 1'b0;
		end
		repeat (60) rdc($urandom_range(5));
		give_verdict();
	end
endmodule : ccr_channel0_regs_test
